// [common/adc_map_pkg.sv]
// constants of the converter register bank: offsets, layouts, resets
// assumes 16-bit registers on a 6-bit register address
package adc_map_pkg;

    // ****************************************
    // sizes and fixed addresses
    // ****************************************
    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;
    localparam int NUM_RW = 16;
    localparam logic [5:0] ADDR_ID     = 6'h00;
    localparam logic [5:0] ADDR_STATUS = 6'h01;
    localparam logic [5:0] ADDR_CRC    = 6'h3e;
    localparam logic [5:0] ADDR_SPARE  = 6'h3f;
    localparam logic [3:0] CHAN_COUNT  = 4'h2;

    // ****************************************
    // command and answer words
    // ****************************************
    localparam int CMD_OP_LO   = 13;
    localparam int CMD_ADDR_LO = 7;
    localparam logic [2:0] OP_READ    = 3'h5;
    localparam logic [2:0] OP_WRITE   = 3'h3;
    localparam logic [2:0] RESP_WRITE = 3'h2;
    localparam logic [2:0] RESP_MULTI = 3'h7;

    // ****************************************
    // field positions
    // ****************************************
    localparam int ID_CNT_LO    = 8;
    localparam int MODE_CRC_TY  = 11;
    localparam int MODE_RST_BIT = 10;
    localparam int MODE_WLEN_LO = 8;
    localparam logic [15:0] STATUS_RESET = 16'h0500;

    // ****************************************
    // word size codes and widths
    // ****************************************
    localparam logic [1:0] WLEN_16  = 2'h0;
    localparam logic [1:0] WLEN_24  = 2'h1;
    localparam logic [1:0] WLEN_32Z = 2'h2;
    localparam logic [1:0] WLEN_32S = 2'h3;
    localparam logic [5:0] BITS_16  = 6'h10;
    localparam logic [5:0] BITS_24  = 6'h18;
    localparam logic [5:0] BITS_32  = 6'h20;

    // ****************************************
    // writable registers: index, offset, reset, mask
    // ****************************************
    localparam int MODE_IDX  = 0;
    localparam int CLOCK_IDX = 1;
    localparam int GAIN_IDX  = 2;
    localparam int CFG_IDX   = 3;
    localparam int THRH_IDX  = 4;
    localparam int THRL_IDX  = 5;
    localparam int CHA_IDX   = 6;
    localparam int CHB_IDX   = 11;

    localparam logic [5:0] RW_ADDR [NUM_RW] = '{
        6'h02, 6'h03, 6'h04, 6'h06, 6'h07, 6'h08,
        6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d,
        6'h0e, 6'h0f, 6'h10, 6'h11, 6'h12};
    localparam logic [15:0] RW_RESET [NUM_RW] = '{
        16'h0510, 16'h030e, 16'h0000, 16'h0600,
        16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000};
    localparam logic [15:0] RW_MASK [NUM_RW] = '{
        16'h3f1f, 16'h033f, 16'h0077, 16'h1fff,
        16'hffff, 16'hff0f,
        16'hffc7, 16'hffff, 16'hff00, 16'hffff, 16'hff00,
        16'hffc7, 16'hffff, 16'hff00, 16'hffff, 16'hff00};

endpackage

// [src/adc_register_map.sv]
// register bank of the two-channel converter behind its command frames
// assumes frame decoding elsewhere hands over command and data words
// as one-cycle strobes; inputs are synchronous to clk

// ****************************************
// rule summary
// ****************************************
// How it works
// - status at 01h, resets 0500h, flags high byte, new-sample bits 1:0
// - global settings at 02h reset 0510h, checksum, word size, ready controls
// - conversion timing at 03h reset 030eh, channel enables, ratio, power
// - amplifier gains at 04h reset 0000h, two three-bit codes
// - chop and detect setup at 06h reset 0600h
// - detect threshold spans 07h and upper byte of 08h, dc setting low nibble
// - channel setups at 09h and 0eh: phase, dc reject off, input select
// - channel offsets: 24 bits over 0ah/0bh and 0fh/10h, reset zero
// - channel gain corrections at 0ch/0dh, 11h/12h, high words reset 8000h
// - map checksum at 3eh and spare at 3fh, both reset zero
// - writes to read-only or unknown addresses are dropped silently
// - single read answers with the register in the next frame
// - word size code: 16, 24, 32 zero padded, 32 sign extended
module adc_register_map #(
    parameter logic [3:0] CHAN_CNT = adc_map_pkg::CHAN_COUNT
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        frameStart,
    input  wire logic        cmdValid,
    input  wire logic [15:0] cmdWord,
    input  wire logic        dataValid,
    input  wire logic [15:0] dataWord,
    input  wire logic        wordNext,
    input  wire logic        locked,
    input  wire logic        resyncFlag,
    input  wire logic        mapCrcFault,
    input  wire logic        rxCrcFault,
    input  wire logic        chanANewSample,
    input  wire logic        chanBNewSample,
    input  wire logic        mapCrcLoad,
    input  wire logic [15:0] mapCrcValue,
    output logic      [15:0] respWord,
    output logic      [15:0] modeWord,
    output logic      [15:0] clockWord,
    output logic      [15:0] gainWord,
    output logic      [15:0] cfgWord,
    output logic      [23:0] detectThreshold,
    output logic      [3:0]  dcRejectSetting,
    output logic      [15:0] chanASetup,
    output logic      [15:0] chanBSetup,
    output logic      [23:0] chanAOffset,
    output logic      [23:0] chanBOffset,
    output logic      [23:0] chanAGainCorr,
    output logic      [23:0] chanBGainCorr,
    output logic      [15:0] mapChecksum,
    output logic      [5:0]  wordBits,
    output logic             signExtend
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [15:0] respWord;
        logic [15:0] lastCmd;
        logic        wrActive;
        logic [5:0]  wrAddr;
        logic [7:0]  wrLeft;
        logic [7:0]  wrCount;
        logic [5:0]  rdAddr;
        logic [7:0]  rdLeft;
        logic [15:0] mapCrc;
        logic [5:0]  wordBits;
        logic        signExt;
    } state_type;

    localparam state_type ST_RST = '{wordBits: adc_map_pkg::BITS_24, default: '0};

    state_type st_r;
    state_type st_nxt;

    logic [15:0]                    regVal [adc_map_pkg::NUM_RW];
    logic [adc_map_pkg::NUM_RW-1:0] wrEn;
    logic                           wrHit;
    logic [15:0]                    idWord;
    logic [15:0]                    statusWord;
    logic [2:0]                     cmdOp;
    logic [5:0]                     cmdAddr;
    logic [6:0]                     cmdCnt;
    logic [2:0]                     inOp;
    logic [5:0]                     inAddr;
    logic [6:0]                     inCnt;
    logic [15:0]                    singleVal;
    logic [1:0]                     wlenCode;

    // ****************************************
    // read-only words
    // ****************************************
    assign idWord = {4'h0, CHAN_CNT, 8'h00};

    // mode bits mirror into the status high byte
    assign statusWord = {locked, resyncFlag, mapCrcFault, rxCrcFault,
                         modeWord[adc_map_pkg::MODE_CRC_TY],
                         modeWord[adc_map_pkg::MODE_RST_BIT],
                         wlenCode,
                         6'h00,
                         chanBNewSample, chanANewSample};

    assign wlenCode = modeWord[adc_map_pkg::MODE_WLEN_LO +: 2];

    // ****************************************
    // command fields
    // ****************************************
    assign cmdOp   = st_r.lastCmd[adc_map_pkg::CMD_OP_LO +: 3];
    assign cmdAddr = st_r.lastCmd[adc_map_pkg::CMD_ADDR_LO +: 6];
    assign cmdCnt  = st_r.lastCmd[6:0];
    assign inOp    = cmdWord[adc_map_pkg::CMD_OP_LO +: 3];
    assign inAddr  = cmdWord[adc_map_pkg::CMD_ADDR_LO +: 6];
    assign inCnt   = cmdWord[6:0];

    // ****************************************
    // writable registers
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < adc_map_pkg::NUM_RW; g++)
        begin : gen_reg
            // only mapped writable offsets decode; all else is dropped
            assign wrEn[g] = dataValid && st_r.wrActive &&
                             (st_r.wrAddr == adc_map_pkg::RW_ADDR[g]);
            reg_word #(
                .RESET_VAL (adc_map_pkg::RW_RESET[g]),
                .WR_MASK   (adc_map_pkg::RW_MASK[g])
            ) u_reg (
                .clk     (clk),
                .sys_rst (sys_rst),
                .wrEn    (wrEn[g]),
                .wrData  (dataWord),
                .value   (regVal[g])
            );
        end
    endgenerate

    assign wrHit = |wrEn;

    // ****************************************
    // read decode
    // ****************************************
    // unmapped offsets and the spare word read zero
    function automatic logic [15:0] readReg(input logic [5:0] a);
        logic [15:0] v;
        v = 16'h0000;
        if (a == adc_map_pkg::ADDR_ID)
            v = idWord;
        else if (a == adc_map_pkg::ADDR_STATUS)
            v = statusWord;
        else if (a == adc_map_pkg::ADDR_CRC)
            v = st_r.mapCrc;
        for (int i = 0; i < adc_map_pkg::NUM_RW; i++)
        begin
            if (a == adc_map_pkg::RW_ADDR[i])
                v = regVal[i];
        end
        return v;
    endfunction

    assign singleVal = readReg(cmdAddr);

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        st_nxt = st_r;
        // write stream: count only words that landed in a register
        if (dataValid && st_r.wrActive)
        begin
            st_nxt.wrAddr = st_r.wrAddr + 6'h01;
            st_nxt.wrLeft = st_r.wrLeft - 8'h01;
            if (wrHit)
                st_nxt.wrCount = st_r.wrCount + 8'h01;
            if (st_r.wrLeft == 8'h01)
                st_nxt.wrActive = 1'b0;
        end
        // multi-word read stream
        if (wordNext && (st_r.rdLeft != 8'h00))
        begin
            st_nxt.respWord = readReg(st_r.rdAddr);
            st_nxt.rdAddr   = st_r.rdAddr + 6'h01;
            st_nxt.rdLeft   = st_r.rdLeft - 8'h01;
        end
        // answer to last frame's command
        if (frameStart)
        begin
            st_nxt.wrActive = 1'b0;
            st_nxt.rdLeft   = 8'h00;
            st_nxt.lastCmd  = 16'h0000;
            if (cmdOp == adc_map_pkg::OP_READ && cmdCnt == 7'h00)
                st_nxt.respWord = singleVal;
            else if (cmdOp == adc_map_pkg::OP_READ)
            begin
                st_nxt.respWord = {adc_map_pkg::RESP_MULTI, cmdAddr, cmdCnt};
                st_nxt.rdAddr   = cmdAddr;
                st_nxt.rdLeft   = {1'b0, cmdCnt} + 8'h01;
            end
            else if (cmdOp == adc_map_pkg::OP_WRITE)
            begin
                if (st_r.wrCount == 8'h00)
                    st_nxt.respWord = {adc_map_pkg::RESP_WRITE, cmdAddr, 7'h00};
                else
                    st_nxt.respWord = {adc_map_pkg::RESP_WRITE, cmdAddr,
                                       7'(st_r.wrCount - 8'h01)};
            end
            else
                st_nxt.respWord = statusWord;
        end
        // new command; writes refused while locked
        if (cmdValid)
        begin
            if (inOp == adc_map_pkg::OP_READ)
                st_nxt.lastCmd = cmdWord;
            else if (inOp == adc_map_pkg::OP_WRITE && !locked)
            begin
                st_nxt.lastCmd  = cmdWord;
                st_nxt.wrActive = 1'b1;
                st_nxt.wrAddr   = inAddr;
                st_nxt.wrLeft   = {1'b0, inCnt} + 8'h01;
                st_nxt.wrCount  = 8'h00;
            end
        end
        if (mapCrcLoad)
            st_nxt.mapCrc = mapCrcValue;
        // word size decode
        case (wlenCode)
            adc_map_pkg::WLEN_16:
            begin
                st_nxt.wordBits = adc_map_pkg::BITS_16;
                st_nxt.signExt  = 1'b0;
            end
            adc_map_pkg::WLEN_24:
            begin
                st_nxt.wordBits = adc_map_pkg::BITS_24;
                st_nxt.signExt  = 1'b0;
            end
            adc_map_pkg::WLEN_32Z:
            begin
                st_nxt.wordBits = adc_map_pkg::BITS_32;
                st_nxt.signExt  = 1'b0;
            end
            default:
            begin
                st_nxt.wordBits = adc_map_pkg::BITS_32;
                st_nxt.signExt  = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            st_r <= ST_RST;
        else
            st_r <= st_nxt;
    end

    // ****************************************
    // outputs
    // ****************************************
    assign respWord        = st_r.respWord;
    assign mapChecksum     = st_r.mapCrc;
    assign wordBits        = st_r.wordBits;
    assign signExtend      = st_r.signExt;
    assign modeWord        = regVal[adc_map_pkg::MODE_IDX];
    assign clockWord       = regVal[adc_map_pkg::CLOCK_IDX];
    assign gainWord        = regVal[adc_map_pkg::GAIN_IDX];
    assign cfgWord         = regVal[adc_map_pkg::CFG_IDX];
    assign detectThreshold = {regVal[adc_map_pkg::THRH_IDX],
                              regVal[adc_map_pkg::THRL_IDX][15:8]};
    assign dcRejectSetting = regVal[adc_map_pkg::THRL_IDX][3:0];
    assign chanASetup      = regVal[adc_map_pkg::CHA_IDX];
    assign chanBSetup      = regVal[adc_map_pkg::CHB_IDX];
    assign chanAOffset     = {regVal[adc_map_pkg::CHA_IDX + 1],
                              regVal[adc_map_pkg::CHA_IDX + 2][15:8]};
    assign chanBOffset     = {regVal[adc_map_pkg::CHB_IDX + 1],
                              regVal[adc_map_pkg::CHB_IDX + 2][15:8]};
    assign chanAGainCorr   = {regVal[adc_map_pkg::CHA_IDX + 3],
                              regVal[adc_map_pkg::CHA_IDX + 4][15:8]};
    assign chanBGainCorr   = {regVal[adc_map_pkg::CHB_IDX + 3],
                              regVal[adc_map_pkg::CHB_IDX + 4][15:8]};

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_single_read: assert property (
        frameStart && cmdOp == adc_map_pkg::OP_READ && cmdCnt == 7'h00
        |=> respWord == $past(singleVal))
        else $error("single read answer wrong");

    a_write_answer: assert property (
        frameStart && cmdOp == adc_map_pkg::OP_WRITE
        |=> respWord[15:13] == adc_map_pkg::RESP_WRITE &&
            respWord[12:7] == $past(cmdAddr))
        else $error("write answer header wrong");

    a_status_reset: assert property (
        $past(sys_rst) |-> statusWord[10:8] == adc_map_pkg::STATUS_RESET[10:8] &&
                           statusWord[7:2] == 6'h00)
        else $error("status after reset wrong");

    a_mode_reset: assert property (
        $past(sys_rst) |-> modeWord == 16'h0510 && wordBits == adc_map_pkg::BITS_24)
        else $error("global settings after reset wrong");

    a_clock_reset: assert property (
        $past(sys_rst) |-> clockWord == 16'h030e && gainWord == 16'h0000)
        else $error("timing or gain after reset wrong");

    a_cfg_reset: assert property (
        $past(sys_rst) |-> cfgWord == 16'h0600 && detectThreshold == 24'h000000)
        else $error("chop setup after reset wrong");

    a_gcal_reset: assert property (
        $past(sys_rst) |-> chanAGainCorr == 24'h800000 &&
                           chanBGainCorr == 24'h800000)
        else $error("gain correction after reset wrong");

    a_drop_write: assert property (
        dataValid && st_r.wrActive && !wrHit
        |=> $stable(modeWord) && $stable(clockWord) &&
            st_r.wrCount == $past(st_r.wrCount))
        else $error("dropped write changed state");

    a_word_sign: assert property (
        wlenCode == adc_map_pkg::WLEN_32S ##1 wlenCode == adc_map_pkg::WLEN_32S
        |-> wordBits == adc_map_pkg::BITS_32 && signExtend)
        else $error("sign extended size wrong");

    a_word_short: assert property (
        wlenCode == adc_map_pkg::WLEN_16 ##1 wlenCode == adc_map_pkg::WLEN_16
        |-> wordBits == adc_map_pkg::BITS_16 && !signExtend)
        else $error("short word size wrong");

    a_rsvd_zero: assert property (
        (gainWord & 16'hff88) == 16'h0000 && idWord[15:12] == 4'h0 &&
        idWord[7:0] == 8'h00)
        else $error("reserved bits not zero");

endmodule

// [src/reg_word.sv]
// one writable 16-bit register with a write mask
// assumes the write strobe is one cycle and already decoded
module reg_word #(
    parameter logic [15:0] RESET_VAL = 16'h0000,
    parameter logic [15:0] WR_MASK   = 16'hffff
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        wrEn,
    input  wire logic [15:0] wrData,
    output logic      [15:0] value
);

    typedef struct packed {
        logic [15:0] value;
    } cell_type;

    cell_type cell_r;
    cell_type cell_nxt;

    // masked bits keep their reset value
    always_comb
    begin
        cell_nxt = cell_r;
        if (wrEn)
        begin
            cell_nxt.value = (cell_r.value & ~WR_MASK) | (wrData & WR_MASK);
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            cell_r <= '{value: RESET_VAL};
        else
            cell_r <= cell_nxt;
    end

    assign value = cell_r.value;

    a_cell_rsvd: assert property (@(posedge clk) disable iff (sys_rst)
        (value & ~WR_MASK) == (RESET_VAL & ~WR_MASK))
        else $error("reserved bits of a register changed");

endmodule

// [testbench/host_model.sv]
// host side of the bank: frame starts, commands, data words, stream steps
// assumes the bench calls frame() once at a time from one process
module host_model (
    input  wire logic        clk,
    output logic             frameStart,
    output logic             cmdValid,
    output logic      [15:0] cmdWord,
    output logic             dataValid,
    output logic      [15:0] dataWord,
    output logic             wordNext
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        frameStart = 1'b0;
        cmdValid = 1'b0;
        cmdWord = 16'h0000;
        dataValid = 1'b0;
        dataWord = 16'h0000;
        wordNext = 1'b0;
    end

    // ****************************************
    // one frame: capture, stream steps, command, data
    // ****************************************
    task automatic frame(input logic [15:0] cmd, input logic [15:0] d [$],
                         input int steps, input bit rogue);
        logic [15:0] c;
        c = cmd;
        // no writes past the map unless a test asks for it
        if (!rogue && c[15:13] == adc_map_pkg::OP_WRITE && c[12:7] > 6'h12)
            c[15:13] = adc_map_pkg::OP_READ;
        @(posedge clk);
        frameStart <= 1'b1;
        @(posedge clk);
        frameStart <= 1'b0;
        repeat (steps)
        begin
            wordNext <= 1'b1;
            @(posedge clk);
        end
        wordNext <= 1'b0;
        cmdValid <= 1'b1;
        cmdWord <= c;
        @(posedge clk);
        cmdValid <= 1'b0;
        cmdWord <= ~c;
        foreach (d[i])
        begin
            dataValid <= 1'b1;
            dataWord <= d[i];
            @(posedge clk);
        end
        dataValid <= 1'b0;
        dataWord <= ~dataWord;
        repeat (2) @(posedge clk);
    endtask
endmodule

// [testbench/testbench.sv]
// self-checking bench of the converter register bank
// assumes host_model drives frames; answers come one frame late
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        due = 1'b0;
    logic        locked, resyncFlag, mapCrcFault, rxCrcFault, mapCrcLoad;
    logic        chanANewSample, chanBNewSample, signExtend;
    logic        frameStart, cmdValid, dataValid, wordNext;
    logic [15:0] cmdWord, dataWord, mapCrcValue, respWord, modeWord, clockWord;
    logic [15:0] gainWord, cfgWord, chanASetup, chanBSetup, mapChecksum;
    logic [23:0] detectThreshold, chanAOffset, chanBOffset, chanAGainCorr, chanBGainCorr;
    logic [3:0]  dcRejectSetting;
    logic [5:0]  wordBits;
    logic [15:0] mdl [64];
    logic [15:0] expq [$];
    logic [15:0] pend [$];
    logic [15:0] d [$];
    logic [15:0] nil [$];
    int          n_fail = 0;
    int          compares = 0;

    host_model host (.clk, .frameStart, .cmdValid, .cmdWord, .dataValid, .dataWord, .wordNext);
    adc_register_map dut (
        .clk, .sys_rst, .frameStart, .cmdValid, .cmdWord, .dataValid, .dataWord, .wordNext,
        .locked, .resyncFlag, .mapCrcFault, .rxCrcFault, .chanANewSample, .chanBNewSample,
        .mapCrcLoad, .mapCrcValue, .respWord, .modeWord, .clockWord, .gainWord, .cfgWord,
        .detectThreshold, .dcRejectSetting, .chanASetup, .chanBSetup, .chanAOffset,
        .chanBOffset, .chanAGainCorr, .chanBGainCorr, .mapChecksum, .wordBits, .signExtend
    );

    initial forever #4 clk = ~clk;

    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ****************************************
    // answer watcher: one note per frame start or stream step
    // ****************************************
    always @(posedge clk)
        due <= frameStart | wordNext;

    initial
        forever
        begin
            @(negedge clk);
            if (due === 1'b1)
                check("respWord", respWord, expq.size() ? expq.pop_front() : 16'hxxxx);
        end

    // ****************************************
    // expected bank contents and command helpers
    // ****************************************
    function automatic logic [15:0] stat();
        return {locked, resyncFlag, mapCrcFault, rxCrcFault, mdl[2][11:8], 6'h00,
                chanBNewSample, chanANewSample};
    endfunction

    function automatic int idx(input int a);
        for (int i = 0; i < adc_map_pkg::NUM_RW; i++)
            if (int'(adc_map_pkg::RW_ADDR[i]) == a)
                return i;
        return -1;
    endfunction

    task automatic resetMdl();
        foreach (mdl[a])
            mdl[a] = 16'h0000;
        mdl[0] = {4'h0, adc_map_pkg::CHAN_COUNT, 8'h00};
        mdl[2] = 16'h0510;
        mdl[3] = 16'h030e;
        mdl[6] = 16'h0600;
        mdl[12] = 16'h8000;
        mdl[17] = 16'h8000;
        pend = '{stat()};
    endtask

    // previous command's answers are due in this frame
    task automatic run(input logic [15:0] cmd, input logic [15:0] dw [$], input bit rogue);
        int s;
        s = pend.size() - 1;
        expq = {expq, pend};
        host.frame(cmd, dw, s, rogue);
    endtask

    task automatic rd(input logic [5:0] a, input int n);
        run({adc_map_pkg::OP_READ, a, 7'(n)}, nil, 1'b0);
        pend = nil;
        if (n > 0)
            pend.push_back({adc_map_pkg::RESP_MULTI, a, 7'(n)});
        for (int i = 0; i <= n; i++)
            pend.push_back(a + i == 1 ? stat() : mdl[a + i]);
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] dw [$], input bit rogue);
        int k;
        int j;
        k = 0;
        foreach (dw[i])
        begin
            j = idx(a + i);
            if (j >= 0 && !locked)
            begin
                mdl[a + i] = dw[i] & adc_map_pkg::RW_MASK[j];
                k++;
            end
        end
        run({adc_map_pkg::OP_WRITE, a, 7'(dw.size() - 1)}, dw, rogue);
        pend = nil;
        if (locked)
            pend.push_back(stat());
        else
            pend.push_back({adc_map_pkg::RESP_WRITE, a, 7'(k > 0 ? k - 1 : 0)});
    endtask

    task automatic flush();
        run(16'h0000, nil, 1'b0);
        pend = '{stat()};
    endtask

    task automatic setIn(input logic [6:0] f);
        {locked, resyncFlag, mapCrcFault, rxCrcFault, chanBNewSample, chanANewSample,
         mapCrcLoad} <= f;
        @(posedge clk);
        pend = '{stat()};
    endtask

    task automatic outs();
        check("modeWord", modeWord, mdl[2]);
        check("clockWord", clockWord, mdl[3]);
        check("gainWord", gainWord, mdl[4]);
        check("cfgWord", cfgWord, mdl[6]);
        check("detectThreshold", detectThreshold, {mdl[7], mdl[8][15:8]});
        check("dcRejectSetting", dcRejectSetting, mdl[8][3:0]);
        check("chanASetup", chanASetup, mdl[9]);
        check("chanBSetup", chanBSetup, mdl[14]);
        check("chanAOffset", chanAOffset, {mdl[10], mdl[11][15:8]});
        check("chanBOffset", chanBOffset, {mdl[15], mdl[16][15:8]});
        check("chanAGainCorr", chanAGainCorr, {mdl[12], mdl[13][15:8]});
        check("chanBGainCorr", chanBGainCorr, {mdl[17], mdl[18][15:8]});
        check("mapChecksum", mapChecksum, mdl[62]);
    endtask

    task automatic resetAll();
        sys_rst <= 1'b1;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        resetMdl();
        outs();
        rd(6'h00, 18);
        flush();
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        end_sim();
    end

    initial
    begin
        {locked, resyncFlag, mapCrcFault, rxCrcFault, chanBNewSample, chanANewSample,
         mapCrcLoad} = 7'h00;
        mapCrcValue = 16'h0000;
        void'($urandom(32'hf7bd));
        resetAll();
        for (int a = 0; a < 19; a++)
            rd(6'(a), 0);
        rd(6'h3e, 0);
        rd(6'h3f, 0);
        rd(6'h20, 0);
        flush();
        $display("test reset_values done");
        for (int i = 0; i < 17; i++)
            d.push_back(16'($urandom));
        wr(6'h02, d, 1'b0);
        rd(6'h00, 18);
        flush();
        outs();
        $display("test block_write done");
        wr(6'h00, d[0:1], 1'b1);
        wr(6'h3e, d[2:3], 1'b1);
        wr(6'h13, d[4:4], 1'b1);
        rd(6'h00, 1);
        rd(6'h3e, 1);
        flush();
        setIn(7'h40);
        wr(6'h04, d[5:5], 1'b0);
        rd(6'h04, 0);
        flush();
        setIn(7'h00);
        $display("test refused_writes done");
        for (int c = 0; c < 4; c++)
        begin
            d = '{16'h0410 | 16'(c << 8)};
            wr(6'h02, d, 1'b0);
            check("wordBits", wordBits, c == 0 ? 16 : c == 1 ? 24 : 32);
            check("signExtend", signExtend, c == 3);
            rd(6'h01, 0);
        end
        flush();
        $display("test word_size done");
        mapCrcValue <= 16'($urandom);
        setIn(7'(($urandom & 32'h7e) | 32'h01));
        setIn({locked, resyncFlag, mapCrcFault, rxCrcFault, chanBNewSample, chanANewSample,
               1'b0});
        mdl[62] = mapCrcValue;
        rd(6'h3e, 1);
        rd(6'h01, 0);
        flush();
        outs();
        setIn(7'h00);
        $display("test checksum_status done");
        resetAll();
        $display("test second_reset done");
        end_sim();
    end
endmodule
